// File: rtl/vrl_defines.svh
// Register offsets, field positions, reset values and timing counts.
// Assumes a 32-bit APB slave clocked by pclk at 20 MHz.
// Function
// RL1: Bandgap powered while brownout, detector or either reference is enabled.
// RL2: Reference control bit 7 enables high reference and requests bandgap.
// RL3: Reference control bit 6 enables low reference and requests bandgap.
// RL4: Reference pin drive acts only while that reference is enabled.
// RL5: Supply monitor control bit 5 shows bandgap stable after power-up.
// RL6: Lone reference request gets a stable bandgap within 50 us.
// RL7: Software polls bandgap stable before using either reference.
// RL8: Supply monitor control bit 4 enables detector and requests bandgap.
// RL9: Trip point is a 4-bit field in bits 3 to 0.
// RL10: Enabled detector with supply at or below trip sets low flag.
// RL11: Enabled low-supply interrupt can wake the device from sleep.
// RL12: Clearing the low flag fails while supply stays at or below trip.
// RL13: Low flag cannot set until bandgap is stable.
// RL14: Trip code all-ones routes the external trip input to the comparator.
// RL15: Software programs trip field before setting the detector enable.
// RL16: Software should clear interrupt enable after first low-supply interrupt.
// RL17: Reference control bits 5 and 4 are pin drives; bits 3-0 read zero.
// RL18: Bandgap stable is read-only and clears whenever bandgap powers down.
`ifndef VRL_DEFINES_SVH
`define VRL_DEFINES_SVH
`define VRL_OFS_REF_CTL   8'h00
`define VRL_OFS_MON_CTL   8'h04
`define VRL_OFS_IRQ_STAT  8'h08
`define VRL_OFS_IRQ_CLR   8'h0C
`define VRL_OFS_IRQ_EN    8'h10
`define VRL_BIT_HREF_EN   7
`define VRL_BIT_LREF_EN   6
`define VRL_BIT_HREF_PIN  5
`define VRL_BIT_LREF_PIN  4
`define VRL_BIT_BG_STABLE 5
`define VRL_BIT_MON_EN    4
`define VRL_BIT_IRQ_LOW   0
`define VRL_BIT_IRQ_BG    1
`define VRL_TRIP_EXT      4'hF
`define VRL_RST_REF       4'h0
`define VRL_RST_TRIP      4'h0
`define VRL_STARTUP_NS    50000
`define VRL_CLK_NS        50
`define VRL_STARTUP_CYC   (`VRL_STARTUP_NS / `VRL_CLK_NS)
`endif

// File: rtl/vrl_pkg.sv
// Types shared by the voltage reference and supply monitor control.
// Assumes the constants of vrl_defines.svh.
package vrl_pkg;
  typedef logic [3:0] vrl_nib_t;
  typedef logic [1:0] vrl_irq_t;
endpackage

// File: rtl/vrl_top.sv
// Bandgap, reference and low-voltage detector control with APB registers.
// Assumes synchronous inputs from the analog comparator and brownout fuse.
`include "vrl_defines.svh"
module vrl_top
  import vrl_pkg::*;
#(
  parameter int STARTUP_CYC = `VRL_STARTUP_CYC,
  parameter int CNT_W       = 11
) (
  // Clock and reset.
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave.
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Analog side.
  input  wire logic        brownout_reset_en,
  input  wire logic        supply_low_cmp,
  output logic             bandgap_power,
  output logic             high_ref_on,
  output logic             low_ref_on,
  output logic             high_ref_pin_drive,
  output logic             low_ref_pin_drive,
  output logic             monitor_on,
  output vrl_nib_t         trip_select,
  output logic             external_trip_input_sel,
  // Interrupt and wake.
  output logic             irq,
  output logic             wake
);

  // Refuses a startup count that the counter cannot reach.
  if (STARTUP_CYC < 1 || STARTUP_CYC >= (1 << CNT_W)) begin : g_bad_cnt
    $error("STARTUP_CYC does not fit the counter");
  end

  typedef struct packed {
    vrl_nib_t         ref_ctl;
    logic             mon_en;
    vrl_nib_t         trip;
    logic [CNT_W-1:0] cnt;
    logic             stable;
    vrl_irq_t         stat;
    vrl_irq_t         ien;
    logic             bg_pwr;
    logic             href_on;
    logic             lref_on;
    logic             href_pin;
    logic             lref_pin;
    logic             mon_on;
    vrl_nib_t         trip_o;
    logic             ext_sel;
    logic             irq;
    logic             wake;
    logic [31:0]      rdata;
    logic             ready;
    logic             err;
  } vrl_state_t;

  vrl_state_t s_r;
  vrl_state_t s_nxt;

  logic       bg_req;
  logic       wr_go;
  logic       setup;
  logic       mapped;
  logic [7:0] mon_rd;
  logic [7:0] ref_rd;
  vrl_irq_t   set_ev;

  always_comb begin
    s_nxt  = s_r;
    setup  = psel && !penable;
    wr_go  = psel && penable && pready && pwrite;
    mapped = (paddr == `VRL_OFS_REF_CTL) || (paddr == `VRL_OFS_MON_CTL) ||
             (paddr == `VRL_OFS_IRQ_STAT) || (paddr == `VRL_OFS_IRQ_CLR) ||
             (paddr == `VRL_OFS_IRQ_EN);
    // Reference control register: enables, pin drives, low nibble zero.
    ref_rd = {s_r.ref_ctl, 4'h0}; // see RL17
    mon_rd = {2'h0, s_r.stable, s_r.mon_en, s_r.trip}; // see RL5 see RL9

    // Register writes take effect at the access edge.
    if (wr_go) begin
      unique case (paddr)
        `VRL_OFS_REF_CTL: begin
          s_nxt.ref_ctl = pwdata[7:4]; // see RL2 see RL3 see RL17
        end
        `VRL_OFS_MON_CTL: begin
          s_nxt.mon_en = pwdata[`VRL_BIT_MON_EN]; // see RL8
          s_nxt.trip   = pwdata[3:0]; // see RL9
        end
        `VRL_OFS_IRQ_CLR: begin
          s_nxt.stat = s_r.stat & ~pwdata[1:0];
        end
        `VRL_OFS_IRQ_EN: begin
          s_nxt.ien = pwdata[1:0];
        end
        default: begin
          s_nxt.ien = s_r.ien;
        end
      endcase
    end

    // Bandgap request from every user of the reference.
    bg_req = s_r.ref_ctl[3] || s_r.ref_ctl[2] || s_r.mon_en ||
             brownout_reset_en; // see RL1 see RL2 see RL3 see RL8

    // Startup wait; restarts on every new power-up.
    if (!bg_req) begin
      s_nxt.cnt    = '0; // see RL18
      s_nxt.stable = 1'b0; // see RL18
    end else if (!s_r.stable) begin
      s_nxt.cnt = s_r.cnt + 1'b1;
      if (s_r.cnt == CNT_W'(STARTUP_CYC - 1)) begin
        s_nxt.stable = 1'b1; // see RL5 see RL6
      end
    end

    // Sticky events; a set beats a clear in the same cycle.
    set_ev[`VRL_BIT_IRQ_LOW] = s_r.mon_en && s_r.stable &&
                               supply_low_cmp; // see RL10 see RL13
    set_ev[`VRL_BIT_IRQ_BG]  = s_nxt.stable && !s_r.stable;
    s_nxt.stat = s_nxt.stat | set_ev; // see RL12

    // Registered outputs.
    s_nxt.bg_pwr   = bg_req; // see RL1
    s_nxt.href_on  = s_r.ref_ctl[3]; // see RL2
    s_nxt.lref_on  = s_r.ref_ctl[2]; // see RL3
    s_nxt.href_pin = s_r.ref_ctl[3] && s_r.ref_ctl[1]; // see RL4
    s_nxt.lref_pin = s_r.ref_ctl[2] && s_r.ref_ctl[0]; // see RL4
    s_nxt.mon_on   = s_r.mon_en; // see RL8
    s_nxt.trip_o   = s_r.trip;
    s_nxt.ext_sel  = s_r.trip == `VRL_TRIP_EXT; // see RL14
    s_nxt.irq      = |(s_r.stat & s_r.ien); // see RL10
    s_nxt.wake     = s_r.stat[`VRL_BIT_IRQ_LOW] &&
                     s_r.ien[`VRL_BIT_IRQ_LOW]; // see RL11

    // APB answer is prepared in the setup cycle.
    s_nxt.ready = setup;
    s_nxt.err   = setup && !mapped;
    s_nxt.rdata = '0;
    if (setup && !pwrite) begin
      unique case (paddr)
        `VRL_OFS_REF_CTL:  s_nxt.rdata = {24'h0, ref_rd};
        `VRL_OFS_MON_CTL:  s_nxt.rdata = {24'h0, mon_rd};
        `VRL_OFS_IRQ_STAT: s_nxt.rdata = {30'h0, s_r.stat};
        `VRL_OFS_IRQ_EN:   s_nxt.rdata = {30'h0, s_r.ien};
        default:           s_nxt.rdata = '0;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r         <= '0;
      s_r.ref_ctl <= `VRL_RST_REF;
      s_r.trip    <= `VRL_RST_TRIP;
      s_r.trip_o  <= `VRL_RST_TRIP;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign prdata                  = s_r.rdata;
  assign pready                  = s_r.ready;
  assign pslverr                 = s_r.err;
  assign bandgap_power           = s_r.bg_pwr;
  assign high_ref_on             = s_r.href_on;
  assign low_ref_on              = s_r.lref_on;
  assign high_ref_pin_drive      = s_r.href_pin;
  assign low_ref_pin_drive       = s_r.lref_pin;
  assign monitor_on              = s_r.mon_on;
  assign trip_select             = s_r.trip_o;
  assign external_trip_input_sel = s_r.ext_sel;
  assign irq                     = s_r.irq;
  assign wake                    = s_r.wake;

  localparam int A_BG_MAX = STARTUP_CYC;

  default clocking a_clk @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_bg_request_power: assert property ( // see RL1
    (s_r.ref_ctl[3] || s_r.ref_ctl[2] || s_r.mon_en || brownout_reset_en)
    |=> bandgap_power)
    else $error("bandgap not powered while requested");

  a_high_ref_write: assert property ( // see RL2
    psel && penable && pready && pwrite && paddr == `VRL_OFS_REF_CTL &&
    pwdata[`VRL_BIT_HREF_EN] |=> ##1 high_ref_on && bandgap_power)
    else $error("high reference write did not enable it");

  a_pin_needs_ref: assert property ( // see RL4
    (!high_ref_pin_drive || high_ref_on) &&
    (!low_ref_pin_drive || low_ref_on))
    else $error("pin driven by a disabled reference");

  a_bg_startup_bound: assert property ( // see RL6
    $rose(bandgap_power) && !brownout_reset_en |->
    (bandgap_power throughout ##[1:A_BG_MAX] s_r.stable) or
    ##[1:A_BG_MAX] !bandgap_power)
    else $error("bandgap not stable within startup time");

  a_bg_stable_clears: assert property ( // see RL18
    !bg_req |=> !s_r.stable && s_r.cnt == '0)
    else $error("stable bit kept while bandgap off");

  a_flag_held_low: assert property ( // see RL13
    !s_r.stable && !s_r.stat[`VRL_BIT_IRQ_LOW] |=>
    !s_r.stat[`VRL_BIT_IRQ_LOW])
    else $error("low flag set before bandgap stable");

  a_flag_sticks_low: assert property ( // see RL12
    s_r.mon_en && s_r.stable && supply_low_cmp |=>
    s_r.stat[`VRL_BIT_IRQ_LOW])
    else $error("low flag clear while supply low");

  a_ext_trip_route: assert property ( // see RL14
    external_trip_input_sel == (trip_select == `VRL_TRIP_EXT))
    else $error("external trip routing wrong");

  a_irq_wake_low: assert property ( // see RL10
    s_r.stat[`VRL_BIT_IRQ_LOW] && s_r.ien[`VRL_BIT_IRQ_LOW] |=>
    irq && wake)
    else $error("low flag did not raise interrupt and wake");

  a_low_ref_write: assert property ( // see RL3
    psel && penable && pready && pwrite && paddr == `VRL_OFS_REF_CTL &&
    pwdata[`VRL_BIT_LREF_EN] |=> ##1 low_ref_on && bandgap_power)
    else $error("low reference write did not enable it");

  a_bg_power_off: assert property ( // see RL1
    !(s_r.ref_ctl[3] || s_r.ref_ctl[2] || s_r.mon_en || brownout_reset_en)
    |=> !bandgap_power)
    else $error("bandgap powered with no user");

  a_high_pin_drive: assert property ( // see RL4
    s_r.ref_ctl[3] && s_r.ref_ctl[1] |=> high_ref_pin_drive)
    else $error("high reference not driven on its pin");

  a_low_pin_drive: assert property ( // see RL4
    s_r.ref_ctl[2] && s_r.ref_ctl[0] |=> low_ref_pin_drive)
    else $error("low reference not driven on its pin");

  a_stable_after_count: assert property ( // see RL5 see RL6
    $rose(s_r.stable) |-> s_r.cnt == CNT_W'(STARTUP_CYC))
    else $error("bandgap stable before the startup count");

  a_stable_held: assert property ( // see RL5
    s_r.stable && bg_req |=> s_r.stable)
    else $error("bandgap stable dropped while powered");

  a_mon_read_word: assert property ( // see RL5 see RL9
    psel && !penable && !pwrite && paddr == `VRL_OFS_MON_CTL |=>
    prdata == {26'h0, $past(s_r.stable), $past(s_r.mon_en),
               $past(s_r.trip)})
    else $error("supply monitor control read wrong");

  a_ref_read_word: assert property ( // see RL17
    psel && !penable && !pwrite && paddr == `VRL_OFS_REF_CTL |=>
    prdata == {24'h0, $past(s_r.ref_ctl), 4'h0})
    else $error("reference control read wrong");

  a_mon_write: assert property ( // see RL8
    psel && penable && pready && pwrite && paddr == `VRL_OFS_MON_CTL &&
    pwdata[`VRL_BIT_MON_EN] |=> ##1 monitor_on && bandgap_power)
    else $error("detector write did not enable it");

  a_trip_write: assert property ( // see RL9
    psel && penable && pready && pwrite && paddr == `VRL_OFS_MON_CTL |=>
    ##1 trip_select == $past(pwdata[3:0], 2))
    else $error("trip field write not applied");

  a_ext_trip_sel: assert property ( // see RL14
    s_r.trip == `VRL_TRIP_EXT |=> external_trip_input_sel)
    else $error("external trip input not selected");

  a_flag_needs_stable: assert property ( // see RL13 see RL10
    $rose(s_r.stat[`VRL_BIT_IRQ_LOW]) |->
    $past(s_r.stable) && $past(s_r.mon_en) && $past(supply_low_cmp))
    else $error("low flag set without a stable low supply");

  a_stat_read_word: assert property ( // see RL10
    psel && !penable && !pwrite && paddr == `VRL_OFS_IRQ_STAT |=>
    prdata == {30'h0, $past(s_r.stat)})
    else $error("status read wrong");

  a_irq_off: assert property ( // see RL10
    (s_r.stat & s_r.ien) == '0 |=> !irq)
    else $error("interrupt raised with no enabled flag");

  a_wake_off: assert property ( // see RL11
    !(s_r.stat[`VRL_BIT_IRQ_LOW] && s_r.ien[`VRL_BIT_IRQ_LOW]) |=> !wake)
    else $error("wake raised without enabled low flag");

  a_clear_when_high: assert property ( // see RL12
    psel && penable && pready && pwrite && paddr == `VRL_OFS_IRQ_CLR &&
    pwdata[`VRL_BIT_IRQ_LOW] &&
    !(s_r.mon_en && s_r.stable && supply_low_cmp) |=>
    !s_r.stat[`VRL_BIT_IRQ_LOW])
    else $error("low flag not cleared with supply high");

endmodule

// File: testbench/test_voltage_ref_and_lvd_control.sv
// Self-checking bench for the reference and supply monitor control.
// Assumes the APB slave of vrl_top on a 50 ns pclk, one clock domain.
`include "vrl_defines.svh"
module test_voltage_ref_and_lvd_control import vrl_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int STUP = 8;
  logic        pclk, presetn, psel, penable, pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd, v;
  logic        pready, pslverr, serr, brownout_reset_en, supply_low_cmp;
  logic        bandgap_power, high_ref_on, low_ref_on, monitor_on;
  logic        high_ref_pin_drive, low_ref_pin_drive, irq, wake;
  logic        external_trip_input_sel;
  vrl_nib_t    trip_select;
  int          err_total, num_checks, seed, i;

  vrl_top #(.STARTUP_CYC(STUP), .CNT_W(11)) u_dut (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .brownout_reset_en, .supply_low_cmp, .bandgap_power,
    .high_ref_on, .low_ref_on, .high_ref_pin_drive, .low_ref_pin_drive,
    .monitor_on, .trip_select, .external_trip_input_sel, .irq, .wake);

  task automatic results();
    $display("Checks %0d, errors %0d.", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
  endtask

  // One APB transfer; read data and error are taken at the pready edge.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (pready !== 1'b1) begin
      err_total++;
      $display("Error at %0t: no pready on APB transfer", $time);
      results();
    end
    rd = prdata;
    serr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // Polls the stable bit with a bounded number of reads.
  task automatic poll();
    int k;
    k = 0;
    do begin
      apb(1'b0, `VRL_OFS_MON_CTL, 32'h0);
      k++;
    end while (rd[5] !== 1'b1 && k < STUP / 2 + 2);
    chk(rd[5], 1'b1);
  endtask

  function automatic logic [31:0] ref_rd(input logic [31:0] w);
    return {24'h0, w[7:4], 4'h0};
  endfunction

  function automatic logic [31:0] ref_out(input logic [31:0] w);
    return {25'h0, w[7] | w[6], w[7], w[6], w[7] & w[5], w[6] & w[4], 2'b00};
  endfunction

  function automatic logic [31:0] outs();
    return {25'h0, bandgap_power, high_ref_on, low_ref_on, high_ref_pin_drive,
            low_ref_pin_drive, monitor_on, external_trip_input_sel};
  endfunction

  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    {brownout_reset_en, supply_low_cmp, serr, rd, v} = '0;
    err_total = 0;
    num_checks = 0;
    seed = 32'h3B7F;
    tick(12);
    presetn <= 1'b1;
    // Reset values, then an unmapped address.
    for (i = 0; i < 5; i++) begin
      apb(1'b0, 8'(4 * i), 32'h0);
      chk(rd, 32'h0);
    end
    apb(1'b0, 8'h14, 32'h0);
    chk({rd[30:0], serr}, 32'h1);
    // Reference control words, all-ones first, then random.
    for (i = 0; i < 12; i++) begin
      v = (i == 0) ? 32'hFFFFFFFF : $random(seed);
      apb(1'b1, `VRL_OFS_REF_CTL, v);
      apb(1'b0, `VRL_OFS_REF_CTL, 32'h0);
      chk(rd, ref_rd(v));
      tick(2);
      chk(outs(), ref_out(v));
    end
    // Lone high reference: stable bit waits, then sets in time.
    apb(1'b1, `VRL_OFS_REF_CTL, 32'h0);
    tick(3);
    apb(1'b1, `VRL_OFS_IRQ_CLR, 32'h3);
    apb(1'b1, `VRL_OFS_IRQ_EN, 32'h2);
    chk({irq, wake}, 2'b00);
    apb(1'b1, `VRL_OFS_REF_CTL, 32'h80);
    apb(1'b0, `VRL_OFS_MON_CTL, 32'h0);
    chk(rd[5], 1'b0);
    poll();
    chk({irq, wake}, 2'b10);
    apb(1'b1, `VRL_OFS_MON_CTL, 32'h20);
    apb(1'b1, `VRL_OFS_REF_CTL, 32'h0);
    tick(2);
    apb(1'b0, `VRL_OFS_MON_CTL, 32'h0);
    chk(rd, 32'h0);
    // Every trip code, detector off.
    for (i = 0; i < 16; i++) begin
      apb(1'b1, `VRL_OFS_MON_CTL, 32'(i));
      apb(1'b0, `VRL_OFS_MON_CTL, 32'h0);
      chk(rd, 32'(i));
      chk({trip_select, external_trip_input_sel}, {i[3:0], i == 15});
    end
    // Detector on with supply low: flag held off until stable.
    supply_low_cmp <= 1'b1;
    apb(1'b1, `VRL_OFS_MON_CTL, 32'h1F);
    apb(1'b1, `VRL_OFS_IRQ_EN, 32'h1);
    apb(1'b0, `VRL_OFS_IRQ_STAT, 32'h0);
    chk({rd[0], irq}, 2'b00);
    poll();
    chk(outs(), 32'h43);
    apb(1'b0, `VRL_OFS_IRQ_STAT, 32'h0);
    chk(rd[0], 1'b1);
    chk({irq, wake}, 2'b11);
    apb(1'b1, `VRL_OFS_IRQ_CLR, 32'h1);
    apb(1'b0, `VRL_OFS_IRQ_STAT, 32'h0);
    chk(rd[0], 1'b1);
    apb(1'b1, `VRL_OFS_IRQ_EN, 32'h0);
    tick(2);
    chk({irq, wake}, 2'b00);
    supply_low_cmp <= 1'b0;
    tick(2);
    apb(1'b1, `VRL_OFS_IRQ_CLR, 32'h3);
    apb(1'b0, `VRL_OFS_IRQ_STAT, 32'h0);
    chk(rd, 32'h0);
    // Brownout alone powers the bandgap.
    apb(1'b1, `VRL_OFS_MON_CTL, 32'h0);
    brownout_reset_en <= 1'b1;
    tick(3);
    chk(bandgap_power, 1'b1);
    brownout_reset_en <= 1'b0;
    tick(3);
    chk(bandgap_power, 1'b0);
    // Mid-run reset drops the reference and monitor outputs, irq, wake and both control registers.
    apb(1'b1, `VRL_OFS_REF_CTL, 32'hF0);
    presetn <= 1'b0;
    tick(2);
    chk(outs(), 32'h0);
    chk({irq, wake}, 2'b00);
    presetn <= 1'b1;
    apb(1'b0, `VRL_OFS_REF_CTL, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, `VRL_OFS_MON_CTL, 32'h0);
    chk(rd, 32'h0);
    results();
  end
endmodule
